// >>> hw/motor_status_pkg.sv
// constants for the motor controller status register bank
`default_nettype none
package motor_status_pkg;
  // register indices as numbered in the map; byte address is index * 4
  localparam logic [7:0]  IDX_ALGO   = 8'he4;
  localparam logic [7:0]  IDX_PARAMS = 8'he6;
  localparam logic [7:0]  IDX_EXTRACT = 8'he8;
  localparam logic [11:0] ADDR_ALGO    = {2'h0, IDX_ALGO, 2'h0};
  localparam logic [11:0] ADDR_PARAMS  = {2'h0, IDX_PARAMS, 2'h0};
  localparam logic [11:0] ADDR_EXTRACT = {2'h0, IDX_EXTRACT, 2'h0};
  localparam logic [11:0] ADDR_INT_STAT = 12'h3c0;
  localparam logic [11:0] ADDR_INT_MASK = 12'h3c4;
  // field positions
  localparam int MOD_LSB   = 16;
  localparam int DUTY_LSB  = 4;
  localparam int READY_BIT = 2;
  localparam int RES_LSB   = 24;
  localparam int BEMF_LSB  = 16;
  localparam int IND_LSB   = 8;
  localparam int DONE_MSB  = 31;
  localparam int FREQ_LSB  = 24;
  // measurement order in the done vector and in the event bits
  localparam int MEAS_R    = 0;
  localparam int MEAS_L    = 1;
  localparam int MEAS_KE   = 2;
  localparam int MEAS_MECH = 3;
  localparam int NUM_MEAS  = 4;
  // interrupt bits: 0 host ready, 1 + measurement index otherwise
  localparam int INT_READY = 0;
  localparam int NUM_EV    = 5;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [4:0]  INT_RESET  = 5'h00;
endpackage : motor_status_pkg
`default_nettype wire

// >>> hw/motor_ctrl_status_regs.sv
// apb status register bank for the sensorless motor controller
// Function
// R1 - algorithm status bits 31..16 show the applied modulation index.
// R2 - algorithm status bits 15..4 show the 12-bit input duty command.
// R3 - algorithm status bit 2 is 0 while defaults load, 1 once host ready.
// R4 - parameter register bits 31..24 show the measured resistance.
// R5 - parameter register bits 23..16 show the measured back-emf constant.
// R6 - parameter register bits 15..8 show the measured inductance.
// R7 - extraction bit 31 is 1 after resistance done, 0 while it runs.
// R8 - extraction bit 30 is 1 after inductance done, 0 while it runs.
// R9 - extraction bit 29 is 1 after back-emf done, 0 while it runs.
// R10 - extraction bit 28 is 1 after speed gain calc done, 0 while it runs.
// R11 - extraction bits 27..24 give the suggested switching frequency code.
// R12 - software leaves unlisted offsets of this group untouched.
// R13 - writes to the three status registers are ignored, reserved bits 0.
//
// The implementer's own choice: the APB register port.
`default_nettype none
module motor_ctrl_status_regs (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // algorithm status sources
  input  wire logic [15:0] applied_modulation_index,
  input  wire logic [11:0] input_duty_command,
  input  wire logic        host_control_ready,
  // parameter extraction results
  input  wire logic [7:0]  measured_resistance,
  input  wire logic [7:0]  measured_back_emf_constant,
  input  wire logic [7:0]  measured_inductance,
  input  wire logic [3:0]  suggested_switching_freq,
  input  wire logic [3:0]  meas_start,
  input  wire logic [3:0]  meas_complete,
  // interrupt
  output logic             irq
);

  typedef struct packed {
    logic [15:0] mod_idx;
    logic [11:0] duty;
    logic        ready;
    logic [7:0]  res;
    logic [7:0]  bemf;
    logic [7:0]  ind;
    logic [3:0]  done;
    logic [3:0]  freq;
    logic [4:0]  int_stat;
    logic [4:0]  int_mask;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] prdata;
  } state_t;

  state_t state_q;
  state_t state_d;

  function automatic logic is_status(input logic [11:0] a);
    is_status = (a == motor_status_pkg::ADDR_ALGO)
             || (a == motor_status_pkg::ADDR_PARAMS)
             || (a == motor_status_pkg::ADDR_EXTRACT);
  endfunction : is_status

  // all five mapped words decoded once, shared by the error check and the checks
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = is_status(a)
            || (a == motor_status_pkg::ADDR_INT_STAT)
            || (a == motor_status_pkg::ADDR_INT_MASK);
  endfunction : addr_hit

  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input state_t      s);
    logic [31:0] w;
    w = motor_status_pkg::RESET_WORD;
    unique case (a)
      motor_status_pkg::ADDR_ALGO: begin
        w[motor_status_pkg::MOD_LSB +: 16] = s.mod_idx; // R1
        w[motor_status_pkg::DUTY_LSB +: 12] = s.duty; // R2
        w[motor_status_pkg::READY_BIT] = s.ready; // R3
      end
      motor_status_pkg::ADDR_PARAMS: begin
        w[motor_status_pkg::RES_LSB +: 8] = s.res; // R4
        w[motor_status_pkg::BEMF_LSB +: 8] = s.bemf; // R5
        w[motor_status_pkg::IND_LSB +: 8] = s.ind; // R6
      end
      motor_status_pkg::ADDR_EXTRACT: begin
        // done bits run from 31 downward in measurement order
        for (int i = 0; i < motor_status_pkg::NUM_MEAS; i++) begin
          w[motor_status_pkg::DONE_MSB - i] = s.done[i]; // R7 R8 R9 R10
        end
        w[motor_status_pkg::FREQ_LSB +: 4] = s.freq; // R11
      end
      motor_status_pkg::ADDR_INT_STAT: begin
        w[4:0] = s.int_stat;
      end
      motor_status_pkg::ADDR_INT_MASK: begin
        w[4:0] = s.int_mask;
      end
      default: begin
        w = motor_status_pkg::RESET_WORD; // R13
      end
    endcase
    read_word = w;
  endfunction : read_word

  logic       access;
  logic       wr_take;
  logic [4:0] events;

  always_comb begin
    state_d = state_q;
    // one wait state: pready rises in the second access cycle
    access = psel && penable && !state_q.pready;
    // a write lands only at the edge where pready is seen high
    wr_take = psel && penable && pwrite && state_q.pready;
    // live sources are registered so a read sees a settled word
    state_d.mod_idx = applied_modulation_index; // R1
    state_d.duty = input_duty_command; // R2
    state_d.ready = host_control_ready; // R3
    state_d.res = measured_resistance; // R4
    state_d.bemf = measured_back_emf_constant; // R5
    state_d.ind = measured_inductance; // R6
    state_d.freq = suggested_switching_freq; // R11
    events = 5'h00;
    events[motor_status_pkg::INT_READY] = host_control_ready
                                        && !state_q.ready;
    for (int i = 0; i < motor_status_pkg::NUM_MEAS; i++) begin
      // completion wins over a start seen in the same cycle
      if (meas_start[i]) begin
        state_d.done[i] = 1'b0; // R7 R8 R9 R10
      end
      if (meas_complete[i]) begin
        state_d.done[i] = 1'b1; // R7 R8 R9 R10
      end
      events[i + 1] = meas_complete[i] && !state_q.done[i];
    end
    // writes to the status words fall through untouched
    if (wr_take && paddr == motor_status_pkg::ADDR_INT_STAT) begin
      state_d.int_stat = state_q.int_stat & ~pwdata[4:0];
    end
    if (wr_take && paddr == motor_status_pkg::ADDR_INT_MASK) begin
      state_d.int_mask = pwdata[4:0];
    end
    // a fresh event survives a clear in the same cycle
    state_d.int_stat = state_d.int_stat | events;
    state_d.irq = |(state_d.int_stat & state_d.int_mask);
    state_d.pready = access;
    state_d.pslverr = access && !addr_hit(paddr);
    state_d.prdata = (access && !pwrite) ? read_word(paddr, state_q)
                                         : motor_status_pkg::RESET_WORD;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata  = state_q.prdata;
  assign pready  = state_q.pready;
  assign pslverr = state_q.pslverr;
  assign irq     = state_q.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read(logic [11:0] a);
    psel && penable && !pwrite && paddr == a ##1 pready;
  endsequence

  sequence s_write(logic [11:0] a);
    psel && penable && pwrite && paddr == a ##1 pready;
  endsequence

  property p_mod_read;
    s_read(motor_status_pkg::ADDR_ALGO)
      |-> prdata[31:16] == $past(applied_modulation_index, 2);
  endproperty
  a_mod_read: assert property (p_mod_read) // R1
    else $error("modulation index field wrong");

  property p_duty_read;
    s_read(motor_status_pkg::ADDR_ALGO)
      |-> prdata[15:4] == $past(input_duty_command, 2);
  endproperty
  a_duty_read: assert property (p_duty_read) // R2
    else $error("duty command field wrong");

  property p_ready_read;
    s_read(motor_status_pkg::ADDR_ALGO)
      |-> prdata[2] == $past(host_control_ready, 2);
  endproperty
  a_ready_read: assert property (p_ready_read) // R3
    else $error("host ready bit wrong");

  property p_res_read;
    s_read(motor_status_pkg::ADDR_PARAMS)
      |-> prdata[31:24] == $past(measured_resistance, 2);
  endproperty
  a_res_read: assert property (p_res_read) // R4
    else $error("resistance field wrong");

  property p_bemf_read;
    s_read(motor_status_pkg::ADDR_PARAMS)
      |-> prdata[23:16] == $past(measured_back_emf_constant, 2);
  endproperty
  a_bemf_read: assert property (p_bemf_read) // R5
    else $error("back emf field wrong");

  property p_ind_read;
    s_read(motor_status_pkg::ADDR_PARAMS)
      |-> prdata[15:8] == $past(measured_inductance, 2)
          && prdata[7:0] == 8'h00;
  endproperty
  a_ind_read: assert property (p_ind_read) // R6
    else $error("inductance field wrong");

  sequence s_run(int i);
    meas_start[i] && !meas_complete[i];
  endsequence

  property p_res_done;
    (meas_complete[0] |=> state_q.done[0])
    and (s_run(0) |=> !state_q.done[0]);
  endproperty
  a_res_done: assert property (p_res_done) // R7
    else $error("resistance done flag wrong");

  // the flag must survive quiet cycles until software gets round to it
  property p_ind_done;
    meas_complete[1] ##1 !meas_start[1] [*3]
      ##1 s_read(motor_status_pkg::ADDR_EXTRACT) |-> prdata[30];
  endproperty
  a_ind_done: assert property (p_ind_done) // R8
    else $error("inductance done not read back");

  property p_ke_run;
    s_run(2) ##1 !meas_complete[2] [*2] |-> !state_q.done[2];
  endproperty
  a_ke_run: assert property (p_ke_run) // R9
    else $error("back emf done set while running");

  property p_mech_done;
    meas_complete[3] |=> state_q.done[3] && state_q.int_stat[4];
  endproperty
  a_mech_done: assert property (p_mech_done) // R10
    else $error("gain calc done or event missing");

  property p_freq_read;
    s_read(motor_status_pkg::ADDR_EXTRACT)
      |-> prdata[27:24] == $past(suggested_switching_freq, 2)
          && prdata[23:0] == 24'h000000;
  endproperty
  a_freq_read: assert property (p_freq_read) // R11
    else $error("switching frequency field wrong");

  property p_ro_write;
    s_write(motor_status_pkg::ADDR_ALGO) |-> !pslverr
      ##1 state_q.int_mask == $past(state_q.int_mask);
  endproperty
  a_ro_write: assert property (p_ro_write) // R13
    else $error("write to status word had an effect");

  property p_irq_level;
    irq == |(state_q.int_stat & state_q.int_mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level wrong");

  property p_status_no_err;
    psel && penable && pwrite && is_status(paddr) ##1 pready |-> !pslverr;
  endproperty
  a_status_no_err: assert property (p_status_no_err) // R13
    else $error("write to status word answered with an error");

  property p_algo_reserved;
    s_read(motor_status_pkg::ADDR_ALGO)
      |-> prdata[3] == 1'h0 && prdata[1:0] == 2'h0;
  endproperty
  a_algo_reserved: assert property (p_algo_reserved) // R13
    else $error("reserved algorithm status bits not zero");

  // an unmapped place must never leak a stale word onto the bus
  property p_unmapped;
    psel && penable && !addr_hit(paddr) ##1 pready
      |-> pslverr && prdata == motor_status_pkg::RESET_WORD;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready held for more than one cycle");

endmodule : motor_ctrl_status_regs
`default_nettype wire

// >>> verification/motor_ctrl_status_regs_tb_top.sv
// self-checking apb bench for the motor status register bank
`default_nettype none
module motor_ctrl_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr, duty_i;
  logic [31:0] pwdata, prdata;
  logic [15:0] mod_i;
  logic        rdy_i;
  logic [7:0]  res_i, bemf_i, ind_i;
  logic [3:0]  freq_i, st_i, cp_i, done_m;
  logic [4:0]  ist_m, msk_m;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int          bad_count, n_tests, cyc, seed;

  motor_ctrl_status_regs dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .applied_modulation_index(mod_i), .input_duty_command(duty_i),
    .host_control_ready(rdy_i), .measured_resistance(res_i),
    .measured_back_emf_constant(bemf_i), .measured_inductance(ind_i),
    .suggested_switching_freq(freq_i), .meas_start(st_i),
    .meas_complete(cp_i), .irq(irq));

  always #20 pclk = ~pclk;

  task end_sim;
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    n_tests++;
    if (sn !== ex) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk

  task chk_bus(input logic [32:0] ex);
    chk("prdata", ex[31:0], prdata);
    chk("pslverr", {31'h0, ex[32]}, {31'h0, pslverr});
  endtask : chk_bus

  // a hang in the bus handshake ends here
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim;
    end
  end

  // pready sampled high closes a transfer: oldest note is its answer
  always @(posedge pclk) begin
    if (pready === 1'h1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'hx;
      chk_bus(e);
    end
  end

  function automatic logic [31:0] w_algo();
    return {mod_i, duty_i, 1'h0, rdy_i, 2'h0};
  endfunction : w_algo

  function automatic logic [31:0] w_ext();
    return {done_m[0], done_m[1], done_m[2], done_m[3], freq_i, 24'h0};
  endfunction : w_ext

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [31:0] ex, input logic er);
    exp_q.push_back({er, ex});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task rd3;
    apb(1'h0, motor_status_pkg::ADDR_ALGO, 32'h0, w_algo(), 1'h0);
    apb(1'h0, motor_status_pkg::ADDR_PARAMS, 32'h0,
        {res_i, bemf_i, ind_i, 8'h0}, 1'h0);
    apb(1'h0, motor_status_pkg::ADDR_EXTRACT, 32'h0, w_ext(), 1'h0);
  endtask : rd3

  task set_in;
    logic [31:0] a, b;
    a = $random(seed);
    b = $random(seed);
    if (a[28] && !rdy_i) ist_m[0] = 1'h1;
    mod_i <= a[15:0];
    duty_i <= a[27:16];
    rdy_i <= a[28];
    res_i <= b[7:0];
    bemf_i <= b[15:8];
    ind_i <= b[23:16];
    freq_i <= b[27:24];
    repeat (2) @(posedge pclk);
  endtask : set_in

  task pulse(input logic [3:0] s, input logic [3:0] c);
    for (int i = 0; i < 4; i++) if (c[i] && !done_m[i]) ist_m[i+1] = 1'h1;
    done_m = (done_m & ~s) | c;
    st_i <= s;
    cp_i <= c;
    @(posedge pclk);
    st_i <= 4'h0;
    cp_i <= 4'h0;
    repeat (2) @(posedge pclk);
  endtask : pulse

  task ck_irq;
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, |(ist_m & msk_m)}, {31'h0, irq});
  endtask : ck_irq

  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mod_i = 16'h0;
    duty_i = 12'h0;
    rdy_i = 1'h0;
    res_i = 8'h0;
    bemf_i = 8'h0;
    ind_i = 8'h0;
    freq_i = 4'h0;
    st_i = 4'h0;
    cp_i = 4'h0;
    done_m = 4'h0;
    ist_m = 5'h00;
    msk_m = 5'h00;
    seed = 89153;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd3;
    apb(1'h0, motor_status_pkg::ADDR_INT_MASK, 32'h0, 32'h0, 1'h0);
    for (int k = 0; k < 6; k++) begin
      set_in;
      rd3;
      apb(1'h1, motor_status_pkg::ADDR_ALGO, $random(seed), 32'h0,
          1'h0);
      apb(1'h1, motor_status_pkg::ADDR_PARAMS, $random(seed), 32'h0,
          1'h0);
      apb(1'h1, motor_status_pkg::ADDR_EXTRACT, 32'hffffffff, 32'h0,
          1'h0);
      rd3;
    end
    // status writes must not have reached the mask by aliasing
    apb(1'h0, motor_status_pkg::ADDR_INT_MASK, 32'h0, 32'h0, 1'h0);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i, 4'h0);
      apb(1'h0, motor_status_pkg::ADDR_EXTRACT, 32'h0, w_ext(), 1'h0);
      pulse(4'h0, 4'h1 << i);
      apb(1'h0, motor_status_pkg::ADDR_EXTRACT, 32'h0, w_ext(), 1'h0);
      pulse(4'h1 << i, 4'h1 << i);
    end
    apb(1'h0, motor_status_pkg::ADDR_INT_STAT, 32'h0, {27'h0, ist_m}, 1'h0);
    ck_irq;
    msk_m = 5'h1f;
    apb(1'h1, motor_status_pkg::ADDR_INT_MASK, 32'h1f, 32'h0, 1'h0);
    ck_irq;
    ist_m = ist_m & 5'h01;
    apb(1'h1, motor_status_pkg::ADDR_INT_STAT, 32'h1e, 32'h0, 1'h0);
    ck_irq;
    msk_m = 5'h02;
    apb(1'h1, motor_status_pkg::ADDR_INT_MASK, 32'h02, 32'h0, 1'h0);
    ck_irq;
    pulse(4'h1, 4'h0);
    pulse(4'h0, 4'h1);
    ck_irq;
    apb(1'h0, motor_status_pkg::ADDR_INT_STAT, 32'h0, {27'h0, ist_m}, 1'h0);
    ist_m = 5'h00;
    apb(1'h1, motor_status_pkg::ADDR_INT_STAT, 32'h1f, 32'h0, 1'h0);
    ck_irq;
    // unmapped places answer with an error and keep nothing
    apb(1'h0, 12'h3cc, 32'h0, 32'h0, 1'h1);
    apb(1'h1, 12'h000, 32'hffffffff, 32'h0, 1'h1);
    rd3;
    end_sim;
  end
endmodule : motor_ctrl_status_regs_tb_top
`default_nettype wire
